// ==== core/ebg_defs.vh ====
`ifndef EBG_DEFS_VH
`define EBG_DEFS_VH

// ==========================================
// Clock and reset timing
`define EBG_CLK_PERIOD_PS   4000
`define EBG_LOCK_CYCLES     2000
`define EBG_LOCK_CNT_W      11
`define EBG_RESET_MIN_CLKS  5

// ==========================================
// Bus handshake states
`define EBG_ST_W            2
`define EBG_ST_OWN          2'h0
`define EBG_ST_RELEASE      2'h1
`define EBG_ST_GRANTED      2'h2
`define EBG_ST_RETURN       2'h3

// ==========================================
// Sampled input lines
`define EBG_IRQ_W           3

`endif

// ==== core/ebg_sampler.v ====
`timescale 1ns/1ps
// ==========================================
// Two-stage input sampler, one lane per line
module ebg_sampler
#(
  parameter W = 4
)
(
  // Clock, enable and reset
  input  wire         clk,
  input  wire         rst_b,
  input  wire         ce,
  // Lines
  input  wire [W-1:0] raw,
  output wire [W-1:0] sampled
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_lane
      // Inputs idle high; the first stage only feeds the second
      always @(posedge clk)
      begin
        if (!rst_b)
        begin
          stage1[i] <= 1'b1;
          stage2[i] <= 1'b1;
        end
        else if (ce)
        begin
          stage1[i] <= raw[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sampled = stage2;

endmodule

// ==== core/ebg_top.v ====
`timescale 1ns/1ps
`include "ebg_defs.vh"
// Summary of operation
// (R1) Reset held low at least five clocks
// (R2) Clock lock reported within 2000 cycles
// (R3) Interrupt and flag recognised this or next cycle (irq_seen and flag_seen update on the third clock after the line changes)
// (R4) Level interrupts held low until serviced
// (R5) Bus request recognised this or next cycle (req_seen goes true on the second clock after bus_request_n falls)
// (R6) Grant asserted the cycle after recognition
// (R7) Asynchronous request synchronised inside the device
// (R8) Strobes released before grant goes low
// (R9) Strobes re-enabled only after grant high
// (R10) Own accesses suspended while grant active
module ebg_top
(
  // Clock, enable and reset
  input  wire                    clk,
  input  wire                    ce,
  input  wire                    rst_b,
  // External bus master handshake
  input  wire                    bus_request_n,
  output reg                     bus_grant_n,
  // Memory strobes from the core
  input  wire                    core_data_space_select_n,
  input  wire                    core_program_space_select_n,
  input  wire                    core_boot_space_select_n,
  input  wire                    core_read_n,
  input  wire                    core_write_n,
  // Memory strobe pins
  output reg                     data_space_select_n,
  output reg                     program_space_select_n,
  output reg                     boot_space_select_n,
  output reg                     read_n,
  output reg                     write_n,
  output reg                     strobe_oe,
  // Core stall while the bus is away
  output reg                     core_bus_hold,
  // Interrupts and flag
  input  wire [`EBG_IRQ_W-1:0]   ext_interrupt_n,
  input  wire                    flag_input,
  output reg  [`EBG_IRQ_W-1:0]   irq_seen,
  output reg                     flag_seen,
  // Clock multiplier status
  output reg                     clock_locked,
  output reg                     reset_too_short
);

  // ==========================================
  // Input sampling
  wire [`EBG_IRQ_W+1:0] sampled;

  ebg_sampler
  #(
    .W (`EBG_IRQ_W + 2)
  )
  u_sampler
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .raw     ({bus_request_n, flag_input, ext_interrupt_n}),
    .sampled (sampled)
  );

  wire req_seen = ~sampled[`EBG_IRQ_W+1]; // R5 R7

  // Level lines are passed through as sampled; holding them is the source's job
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      irq_seen  <= {`EBG_IRQ_W{1'b0}};
      flag_seen <= 1'b0;
    end
    else if (ce)
    begin
      irq_seen  <= ~sampled[`EBG_IRQ_W-1:0]; // R3 R4
      flag_seen <= sampled[`EBG_IRQ_W];      // R3
    end
  end

  // ==========================================
  // Bus request and grant
  reg [`EBG_ST_W-1:0] state;
  reg [`EBG_ST_W-1:0] next_state;

  always @*
  begin
    case (state)
      `EBG_ST_OWN:     next_state = req_seen ? `EBG_ST_RELEASE : `EBG_ST_OWN;
      `EBG_ST_RELEASE: next_state = `EBG_ST_GRANTED; // R6
      `EBG_ST_GRANTED: next_state = req_seen ? `EBG_ST_GRANTED : `EBG_ST_RETURN;
      `EBG_ST_RETURN:  next_state = `EBG_ST_OWN;
      default:         next_state = `EBG_ST_OWN;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state                  <= `EBG_ST_OWN;
      bus_grant_n            <= 1'b1;
      strobe_oe              <= 1'b1;
      core_bus_hold          <= 1'b0;
      data_space_select_n    <= 1'b1;
      program_space_select_n <= 1'b1;
      boot_space_select_n    <= 1'b1;
      read_n                 <= 1'b1;
      write_n                <= 1'b1;
    end
    else if (ce)
    begin
      state <= next_state;
      // Strobes drop one cycle before grant falls
      strobe_oe     <= (next_state == `EBG_ST_OWN); // R8 R9
      bus_grant_n   <= (next_state != `EBG_ST_GRANTED); // R6 R8
      core_bus_hold <= (next_state != `EBG_ST_OWN); // R10
      // Idle values while released so pins are clean on re-enable
      if (next_state == `EBG_ST_OWN)
      begin
        data_space_select_n    <= core_data_space_select_n;
        program_space_select_n <= core_program_space_select_n;
        boot_space_select_n    <= core_boot_space_select_n;
        read_n                 <= core_read_n;
        write_n                <= core_write_n;
      end
      else
      begin
        data_space_select_n    <= 1'b1;
        program_space_select_n <= 1'b1;
        boot_space_select_n    <= 1'b1;
        read_n                 <= 1'b1;
        write_n                <= 1'b1;
      end
    end
  end

  // ==========================================
  // Reset width check and lock timer
  reg [2:0]                  rst_cnt;
  reg [`EBG_LOCK_CNT_W-1:0]  lock_cnt;

  // Counts low reset clocks; flag latched at release if too few
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      if (rst_cnt != 3'h7)
        rst_cnt <= rst_cnt + 3'h1;
    end
    else
      rst_cnt <= 3'h0;
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      lock_cnt        <= {`EBG_LOCK_CNT_W{1'b0}};
      clock_locked    <= 1'b0;
      reset_too_short <= 1'b0;
    end
    else if (ce)
    begin
      if (rst_cnt != 3'h0)
        reset_too_short <= (rst_cnt < `EBG_RESET_MIN_CLKS); // R1
      if (lock_cnt == `EBG_LOCK_CYCLES - 1)
        clock_locked <= 1'b1; // R2
      else
        lock_cnt <= lock_cnt + 11'h1;
    end
  end

endmodule

// ==== test/ebg_chk_asserts.sv ====
`timescale 1ns/1ps
// ====
// Checks
module ebg_chk
(
  input wire clk, ce, rst_b, bus_request_n, bus_grant_n, strobe_oe, core_bus_hold,
  input wire clock_locked,
  input wire [2:0] ext_interrupt_n, irq_seen
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_GRANT: assert property ($fell(bus_request_n) && bus_grant_n && strobe_oe
    |-> ##4 $fell(bus_grant_n)) else $error("grant");
  AST_RETURN: assert property ($rose(bus_request_n) && !bus_grant_n
    |-> ##3 $rose(bus_grant_n)) else $error("return");
  AST_OFF: assert property ($fell(bus_grant_n) |-> !$past(strobe_oe)) else $error("off");
  AST_ORDER: assert property ($fell(strobe_oe) && !bus_request_n
    |-> ##1 $fell(bus_grant_n)) else $error("order");
  AST_ON: assert property ($rose(strobe_oe) |-> $past(bus_grant_n)) else $error("on");
  AST_HOLD: assert property (!bus_grant_n |-> core_bus_hold) else $error("hold");
  AST_IRQ: assert property (($stable(ext_interrupt_n) && ce && $past(rst_b, 4)) [*4]
    |-> irq_seen == ~ext_interrupt_n) else $error("irq");
  // Early lock only; the bench catches a late one
  AST_LOCK: assert property ($rose(clock_locked) |-> $past(rst_b, 1999)) else $error("lock");
endmodule

// ==== test/ebg_master.sv ====
`timescale 1ns/1ps
// ====
// Bus master
module ebg_master
(
  input  wire clk,
  input  wire bus_grant_n,
  output reg  bus_request_n = 1'b1
);
  task take(input integer hold, output integer on, output integer off);
    @(negedge clk);
    bus_request_n = 1'b0;
    for (on = 0; on < 20 && bus_grant_n; on++) @(negedge clk);
    repeat (hold) @(negedge clk);
    bus_request_n = 1'b1;
    for (off = 0; off < 20 && !bus_grant_n; off++) @(negedge clk);
  endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
// ====
// Bench
module tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg ce = 1'b1;
  wire reset_too_short;
  reg core_data_space_select_n = 1'b1, core_program_space_select_n = 1'b1;
  reg core_boot_space_select_n = 1'b1, core_read_n = 1'b1, core_write_n = 1'b1;
  reg [2:0] ext_interrupt_n = 3'h7;
  reg flag_input = 1'b0;
  wire bus_request_n, bus_grant_n, strobe_oe, core_bus_hold, flag_seen, clock_locked;
  wire data_space_select_n, program_space_select_n, boot_space_select_n, read_n, write_n;
  wire [2:0] irq_seen;
  integer err_count = 0, total_checks = 0, i, on, off;
  always #2 clk = ~clk;
  ebg_top dut_u (.*);
  ebg_master m_u (.*);
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t %h %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("errors %0d of %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task t_bus(input integer hold);
    m_u.take(hold, on, off);
    check({on[7:0], off[7:0]}, 16'h0403);
    if (on == 20 || off == 20)
      end_sim;
    check({strobe_oe, core_bus_hold, read_n}, 3'h3);
    @(negedge clk);
    check({strobe_oe, core_bus_hold, read_n}, 3'h4);
  endtask
  // Frozen enable must hold the sampled lines
  task t_ce;
    ce = 1'b0;
    ext_interrupt_n = 3'h5;
    repeat (5) @(negedge clk);
    check(irq_seen, 3'h0);
    ce = 1'b1;
    repeat (5) @(negedge clk);
    check(irq_seen, 3'h2);
    ext_interrupt_n = 3'h7;
    repeat (5) @(negedge clk);
  endtask
  // Short reset flagged, a full one clears the flag
  task t_rst;
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check({reset_too_short, clock_locked}, 2'h2);
    rst_b = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (2010) @(negedge clk);
    check({reset_too_short, clock_locked}, 2'h1);
  endtask
  task t_irq;
    for (i = 0; i < 4; i++)
    begin
      ext_interrupt_n = ~(3'h1 << i);
      flag_input = i[0];
      repeat (5) @(negedge clk);
      check({irq_seen, flag_seen}, {3'h1 << i, i[0]});
    end
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (2010) @(negedge clk);
    check(clock_locked, 1'b1);
    core_read_n = 1'b0;
    t_bus(0);
    t_bus(0);
    t_bus(25);
    t_irq;
    t_ce;
    t_rst;
    t_bus(0);
    end_sim;
  end
endmodule
bind ebg_top ebg_chk chk_u (.*);
